// File: verilog/ocd_decoder.sv
// opcode decoder: first byte to operation, length and operand form
// Contract
// - undefined opcodes raise hardware trap, no execution
// - short alu form chosen by second-byte nibble
// - short alu pointer limited to two bits
// - jump condition comes from opcode high nibble
// - condition aliases share one encoding
// - bit position from high nibble, E clear F set
// - special register by physical or 8-bit number
// - sign-extend displacement; seven-bit trap number
`timescale 1ns/1ns
`default_nettype none
module ocd_decoder
    import ocd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fetched instruction from fetch stage
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_bytes,
    input wire logic short_reg_mode,
    // decoded controls to execute and trap logic
    output ocd_dec_t dec,
    output logic hw_trap
);
    logic [7:0] op;
    logic [7:0] op2;
    logic tbl_defined;
    logic tbl_four;
    ocd_dec_t next_dec;
    logic next_hw_trap;
    logic is_trap;
    logic is_jump;
    logic is_bit;
    logic is_short;

    // all checks below run on the decode clock and sleep through reset
    default clocking decode_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    assign op = fetch_bytes[7:0];
    assign op2 = fetch_bytes[15:8];

    // opcode classes; tested in priority order, so overlap is harmless
    assign is_trap = (op == OCD_OP_TRAP);
    assign is_jump = (op[3:0] == OCD_NIB_JUMP);
    assign is_bit = (op[3:0] == OCD_NIB_CLR) || (op[3:0] == OCD_NIB_SET);
    // short alu forms only live in the lower half of the map
    assign is_short = !op[7] && (op[3:0] == OCD_NIB_SHORT0 ||
                      op[3:0] == OCD_NIB_SHORT1);

    // sign-extended word offset in bytes, relative to next instruction
    function automatic logic [15:0] word_offset(input logic [7:0] d);
        word_offset = {{7{d[7]}}, d, 1'b0};
    endfunction : word_offset

    ocd_length_rom u_len (
        .opcode(op),
        .defined(tbl_defined),
        .four_bytes(tbl_four)
    );

    // combinational decode of one fetched instruction
    always_comb begin
        next_dec = '0;
        next_hw_trap = 1'b0;
        if (fetch_valid) begin
            next_dec.valid = 1'b1;
            next_dec.opcode = op;
            next_dec.four_bytes = tbl_four;
            next_dec.kind = OCD_OP_OTHER;
            // short register number bypasses page pointers
            next_dec.short_reg_addr = short_reg_mode;
            next_dec.reg_number = op2;
            if (!tbl_defined) begin
                next_dec.kind = OCD_OP_UNDEF;
                next_dec.four_bytes = 1'b0;
                next_dec.hw_trap = 1'b1;
                next_hw_trap = 1'b1;
            end else if (is_trap) begin
                next_dec.kind = OCD_OP_SW_TRAP;
                next_dec.trap_number_immediate = op2[7:1];
            end else if (is_jump) begin
                next_dec.kind = OCD_OP_REL_JUMP;
                // one code per condition, aliases fold together
                next_dec.cond = op[7:4];
                next_dec.rel_offset = word_offset(op2);
            end else if (is_bit) begin
                next_dec.kind = (op[3:0] == OCD_NIB_SET) ?
                    OCD_OP_BIT_SET : OCD_OP_BIT_CLR;
                next_dec.bit_pos = op[7:4];
            end else if (is_short) begin
                next_dec.kind = OCD_OP_SHORT_ALU;
                next_dec.imm3 = op2[2:0];
                next_dec.pointer_reg = op2[1:0];
                if (op2[3:0] >= OCD_FORM_INC_LO)
                    next_dec.form = OCD_FORM_IND_INC;
                else if (op2[3:0] >= OCD_FORM_IND_LO)
                    next_dec.form = OCD_FORM_IND;
                else
                    next_dec.form = OCD_FORM_IMM3;
            end
        end
    end

    // register decoded controls; outputs come from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dec <= '0;
            hw_trap <= 1'b0;
        end else begin
            dec <= next_dec;
            hw_trap <= next_hw_trap;
        end
    end

    // undefined opcode traps on the next edge
    undef_trap_a: assert property (
        fetch_valid && !tbl_defined |=> hw_trap && dec.kind == OCD_OP_UNDEF)
        else $error("undefined opcode did not trap");

    // defined opcode never traps
    no_trap_a: assert property (
        !(fetch_valid && !tbl_defined) |=> !hw_trap)
        else $error("spurious hardware trap");

    // a trapped opcode reports no length and flags the trap in the word
    undef_len_a: assert property (
        fetch_valid && !tbl_defined |=> !dec.four_bytes && dec.hw_trap)
        else $error("undefined opcode carried a length");

    // lower-half opcodes ending in 8 or 9 are the short alu group
    short_kind_a: assert property (
        fetch_valid && !op[7] && op[3:1] == 3'h4 |=>
        dec.kind == OCD_OP_SHORT_ALU)
        else $error("short alu opcode missed");

    // immediate form exactly when second-byte bit 3 is clear
    short_form_a: assert property (
        dec.kind == OCD_OP_SHORT_ALU |->
        (dec.form == OCD_FORM_IMM3) == ($past(op2[3]) == 1'b0))
        else $error("short form mismatch");

    // post-increment form exactly for nibbles c to f
    short_inc_a: assert property (
        dec.kind == OCD_OP_SHORT_ALU |->
        (dec.form == OCD_FORM_IND_INC) == ($past(op2[3:2]) == 2'h3))
        else $error("post-increment form mismatch");

    // three-bit immediate taken from the second byte
    imm_field_a: assert property (
        dec.kind == OCD_OP_SHORT_ALU |-> dec.imm3 == $past(op2[2:0]))
        else $error("short immediate wrong");

    // pointer equals low bits of second byte
    ptr_sel_a: assert property (
        dec.kind == OCD_OP_SHORT_ALU |-> dec.pointer_reg == $past(op2[1:0]))
        else $error("pointer select wrong");

    // jump condition is high nibble
    jump_cond_a: assert property (
        fetch_valid && op[3:0] == OCD_NIB_JUMP |=>
        dec.kind == OCD_OP_REL_JUMP && dec.cond == $past(op[7:4]))
        else $error("jump condition wrong");

    // equal and zero are one opcode, so one condition code
    alias_code_a: assert property (
        fetch_valid && op == 8'h2d |=>
        dec.kind == OCD_OP_REL_JUMP && dec.cond == 4'h2)
        else $error("alias condition wrong");

    // relative jumps are always two bytes
    jump_len_a: assert property (
        dec.kind == OCD_OP_REL_JUMP |-> !dec.four_bytes)
        else $error("jump length wrong");

    // bit position and direction for set
    bit_op_a: assert property (
        fetch_valid && op[3:0] == OCD_NIB_SET |=>
        dec.kind == OCD_OP_BIT_SET && dec.bit_pos == $past(op[7:4]))
        else $error("bit set decode wrong");

    // bit position and direction for clear
    bit_clr_a: assert property (
        fetch_valid && op[3:0] == OCD_NIB_CLR |=>
        dec.kind == OCD_OP_BIT_CLR && dec.bit_pos == $past(op[7:4]))
        else $error("bit clear decode wrong");

    // single-bit operations are two bytes
    bit_len_a: assert property (
        (dec.kind == OCD_OP_BIT_SET || dec.kind == OCD_OP_BIT_CLR) |->
        !dec.four_bytes)
        else $error("bit operation length wrong");

    // displacement sign
    rel_sign_a: assert property (
        dec.kind == OCD_OP_REL_JUMP |-> dec.rel_offset[15] == $past(op2[7]))
        else $error("displacement sign wrong");

    // whole offset: displacement doubled, sign copied upward
    rel_value_a: assert property (
        dec.kind == OCD_OP_REL_JUMP |-> dec.rel_offset[0] == 1'b0 &&
        dec.rel_offset[8:1] == $past(op2) &&
        dec.rel_offset[15:8] == {8{$past(op2[7])}})
        else $error("displacement value wrong");

    // software trap number from the top seven bits of the second byte
    trap_num_a: assert property (
        fetch_valid && op == OCD_OP_TRAP |=>
        dec.kind == OCD_OP_SW_TRAP && !hw_trap &&
        dec.trap_number_immediate == $past(op2[7:1]))
        else $error("trap number wrong");

    // short register mode carried
    short_reg_a: assert property (
        fetch_valid |=> dec.short_reg_addr == $past(short_reg_mode))
        else $error("register address mode lost");

    // register number is the second byte unchanged
    reg_num_a: assert property (
        fetch_valid |=> dec.reg_number == $past(op2))
        else $error("register number wrong");

    // idle is four bytes
    length_a: assert property (
        fetch_valid && op == 8'h87 |=> dec.four_bytes)
        else $error("length wrong");

    // nop is two bytes
    nop_len_a: assert property (
        fetch_valid && op == 8'hcc |=> dec.valid && !dec.four_bytes)
        else $error("nop length wrong");

    // nothing fetched means an empty decode word and no trap
    idle_clear_a: assert property (
        !fetch_valid |=> dec == '0 && !hw_trap)
        else $error("stale decode after idle cycle");

    // every fetched opcode shows up valid with its own byte
    valid_a: assert property (
        fetch_valid |=> dec.valid && dec.opcode == $past(op))
        else $error("decode word not valid");
endmodule : ocd_decoder
`default_nettype wire

// File: verilog/ocd_pkg.sv
// shared types and constants for the opcode decoder
package ocd_pkg;
    localparam int OCD_LEN_SHORT = 2;
    localparam int OCD_LEN_LONG = 4;
    localparam logic [3:0] OCD_NIB_JUMP = 4'hd;
    localparam logic [3:0] OCD_NIB_CLR = 4'he;
    localparam logic [3:0] OCD_NIB_SET = 4'hf;
    localparam logic [3:0] OCD_NIB_SHORT0 = 4'h8;
    localparam logic [3:0] OCD_NIB_SHORT1 = 4'h9;
    localparam logic [7:0] OCD_OP_TRAP = 8'h9b;
    localparam logic [3:0] OCD_FORM_IND_LO = 4'h8;
    localparam logic [3:0] OCD_FORM_INC_LO = 4'hc;

    typedef enum logic [1:0] {
        OCD_FORM_NONE,
        OCD_FORM_IMM3,
        OCD_FORM_IND,
        OCD_FORM_IND_INC
    } ocd_form_t;

    typedef enum logic [2:0] {
        OCD_OP_OTHER,
        OCD_OP_SHORT_ALU,
        OCD_OP_REL_JUMP,
        OCD_OP_BIT_CLR,
        OCD_OP_BIT_SET,
        OCD_OP_SW_TRAP,
        OCD_OP_UNDEF
    } ocd_kind_t;

    typedef struct packed {
        logic valid;
        ocd_kind_t kind;
        logic [7:0] opcode;
        logic four_bytes;
        ocd_form_t form;
        logic [1:0] pointer_reg;
        logic [2:0] imm3;
        logic [3:0] cond;
        logic [3:0] bit_pos;
        logic [15:0] rel_offset;
        logic [6:0] trap_number_immediate;
        logic short_reg_addr;
        logic [7:0] reg_number;
        logic hw_trap;
    } ocd_dec_t;
endpackage : ocd_pkg

// File: verilog/ocd_length_rom.sv
// length and defined-ness table for first opcode bytes
`timescale 1ns/1ns
`default_nettype none
module ocd_length_rom
    import ocd_pkg::*;
(
    // opcode in
    input wire logic [7:0] opcode,
    // table out
    output logic defined,
    output logic four_bytes
);
    // undefined codes listed explicitly; everything else is defined
    always_comb begin
        defined = 1'b1;
        case (opcode)
            8'h3b, 8'h44, 8'h45, 8'h83, 8'h85, 8'h8b, 8'h8c, 8'h93,
            8'h95, 8'ha3, 8'hb3, 8'hc1, 8'hc3, 8'hc7, 8'hd1, 8'hd3,
            8'hd7, 8'hdc, 8'he3, 8'he5, 8'hf5, 8'hf8,
            8'hf9: defined = 1'b0;
            default: defined = 1'b1;
        endcase
    end

    // four-byte forms; low nibble patterns cover most, rest listed
    always_comb begin
        four_bytes = 1'b0;
        if (opcode[7:4] < 4'h8) begin
            case (opcode[3:0])
                4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha: four_bytes = 1'b1;
                default: four_bytes = 1'b0;
            endcase
        end else begin
            case (opcode)
                8'h82, 8'h84, 8'h86, 8'h87, 8'h8a, 8'h92, 8'h94, 8'h96,
                8'h97, 8'h9a, 8'ha2, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'haa,
                8'hb2, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hba, 8'hc2, 8'hc4,
                8'hc5, 8'hc6, 8'hca, 8'hd2, 8'hd4, 8'hd5, 8'hd6, 8'hda,
                8'he2, 8'he4, 8'he6, 8'he7, 8'hea, 8'hf2, 8'hf3, 8'hf4,
                8'hf6, 8'hf7, 8'hfa: four_bytes = 1'b1;
                default: four_bytes = 1'b0;
            endcase
        end
    end
endmodule : ocd_length_rom
`default_nettype wire

// File: verification/ocd_fetch_model.sv
// fetch stage model presenting instruction words to the decoder
`timescale 1ns/1ns
`default_nettype none
module ocd_fetch_model (
    // clock
    input wire logic core_clk,
    // fetched instruction out
    output logic fetch_valid,
    output logic [31:0] fetch_bytes
);
    initial begin
        fetch_valid = 1'b0;
        fetch_bytes = 32'h0;
    end
    // one word for one cycle, then inverted bytes so stale data never passes
    task automatic present(input logic [31:0] b);
        @(negedge core_clk);
        fetch_valid = 1'b1;
        fetch_bytes = b;
        @(negedge core_clk);
        fetch_valid = 1'b0;
        fetch_bytes = ~b;
    endtask : present
endmodule : ocd_fetch_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
module testbench
    import ocd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic short_reg_mode = 1'b0;
    logic fetch_valid;
    logic [31:0] fetch_bytes;
    ocd_dec_t dec;
    logic hw_trap;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] undef_ops [23] = '{8'h3b, 8'h44, 8'h45, 8'h83, 8'h85, 8'h8b,
        8'h8c, 8'h93, 8'h95, 8'ha3, 8'hb3, 8'hc1, 8'hc3, 8'hc7, 8'hd1, 8'hd3,
        8'hd7, 8'hdc, 8'he3, 8'he5, 8'hf5, 8'hf8, 8'hf9};

    always #50 core_clk = ~core_clk;
    // fetch side and decoder
    ocd_fetch_model ocd_fetch_model_inst (.core_clk(core_clk),
        .fetch_valid(fetch_valid), .fetch_bytes(fetch_bytes));
    ocd_decoder ocd_decoder_inst (.core_clk(core_clk), .rst(rst),
        .fetch_valid(fetch_valid), .fetch_bytes(fetch_bytes),
        .short_reg_mode(short_reg_mode), .dec(dec), .hw_trap(hw_trap));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // returns at the falling edge where the decode is on the outputs
    task automatic feed(input logic [31:0] b);
        ocd_fetch_model_inst.present(b);
    endtask : feed
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // every undefined code traps, and the trap lasts one cycle
    task automatic t_undef();
        foreach (undef_ops[i]) begin
            feed({24'h0, undef_ops[i]});
            check(dec.kind, OCD_OP_UNDEF);
            check(hw_trap, 1'b1);
            check({dec.four_bytes, dec.hw_trap}, 2'b01);
        end
        @(negedge core_clk);
        check(hw_trap, 1'b0);
    endtask : t_undef
    // all sixteen second-byte nibbles, even ones on opcode 08 and odd ones on 79
    task automatic t_short();
        logic [1:0] f;
        for (int n = 0; n < 16; n++) begin
            f = OCD_FORM_IMM3;
            if (n >= 12) begin
                f = OCD_FORM_IND_INC;
            end else if (n >= 8) begin
                f = OCD_FORM_IND;
            end
            feed({16'h0, 4'h5, n[3:0], n[0] ? 8'h79 : 8'h08});
            check(dec.kind, OCD_OP_SHORT_ALU);
            check(dec.form, f);
            check(dec.pointer_reg, n[1:0]);
            check(dec.imm3, n[2:0]);
        end
    endtask : t_short
    // all conditions, aliases included, with both displacement signs
    task automatic t_jump();
        logic [7:0] d;
        for (int h = 0; h < 16; h++) begin
            d = {h[3:0], ~h[3:0]};
            feed({16'h0, d, h[3:0], 4'hd});
            check(dec.kind, OCD_OP_REL_JUMP);
            check(dec.cond, h[3:0]);
            check(dec.rel_offset, 16'({{8{d[7]}}, d} << 1));
        end
        // not-equal, two words back: offset of minus four bytes
        feed(32'h0000_fe3d);
        check({dec.cond, dec.rel_offset}, 20'h3fffc);
    endtask : t_jump
    // every bit position, clear then set
    task automatic t_bits();
        for (int h = 0; h < 32; h++) begin
            feed({24'h0, h[3:0], 3'h7, h[4]});
            check(dec.kind, h[4] ? OCD_OP_BIT_SET : OCD_OP_BIT_CLR);
            check(dec.bit_pos, h[3:0]);
            check(dec.four_bytes, 1'b0);
        end
    endtask : t_bits
    // trap number, register addressing modes and a long instruction
    task automatic t_misc();
        feed({16'h0, 8'hff, OCD_OP_TRAP});
        check({dec.kind, dec.trap_number_immediate},
            {OCD_OP_SW_TRAP, 7'h7f});
        check(hw_trap, 1'b0);
        short_reg_mode = 1'b1;
        feed({16'h0, 8'h88, 8'hf2});
        check({dec.short_reg_addr, dec.reg_number}, 9'h188);
        check(dec.four_bytes, 1'b1);
        short_reg_mode = 1'b0;
        feed({16'h0, 8'h88, 8'hf2});
        check(dec.short_reg_addr, 1'b0);
        // idle is a long opcode, nop a short one
        feed(32'h0000_0087);
        check({dec.valid, dec.opcode, dec.four_bytes}, 10'h30f);
        feed(32'h0000_00cc);
        check({dec.kind, dec.four_bytes}, {OCD_OP_OTHER, 1'b0});
        @(negedge core_clk);
        check(dec.valid, 1'b0);
    endtask : t_misc
    // reset in mid-run drops a pending decode, then decoding resumes
    task automatic t_reset();
        rst = 1'b1;
        feed({24'h0, 8'h3b});
        check(dec, 64'h0);
        check(hw_trap, 1'b0);
        rst = 1'b0;
        feed({24'h0, 8'h3b});
        check(hw_trap, 1'b1);
    endtask : t_reset
    // reset, then the scenarios in turn
    initial begin
        repeat (4) @(negedge core_clk);
        check(dec, 64'h0);
        check(hw_trap, 1'b0);
        rst = 1'b0;
        t_undef();
        t_short();
        t_jump();
        t_bits();
        t_misc();
        t_reset();
        finish_test();
    end
    // hang guard well beyond the roughly two hundred cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
